// *** common/toggle_timer_pkg.sv ***
// Purpose: shared constants and types for the dual toggle compare timer
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes:   register index is the byte address divided by four
package toggle_timer_pkg;

	// ------------------------------------------------------------
	// widths and values after reset
	// ------------------------------------------------------------
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] PERIOD_RST    = 16'h2EDF; // 11999
	localparam logic [CNT_W-1:0] CMP_A_RST     = 16'h176F; // 5999
	localparam logic [CNT_W-1:0] CMP_B_RST     = 16'h270F; // 9999
	localparam logic [CNT_W-1:0] CNT_RST       = 16'h0000;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PERIOD  = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CMP_A   = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_CMP_B   = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_COUNT   = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h14;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_RUN_BIT   = 0;
	localparam int STAT_RUN_BIT   = 0;
	localparam int STAT_OUT_A_BIT = 1;
	localparam int STAT_OUT_B_BIT = 2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} run_state_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
		logic              wr;
		logic              rd;
	} bus_req_s;

endpackage

// *** hw/period_counter.sv ***
// Purpose: up counter from zero that wraps at the period value
// Assumes: period written before or while running
// Notes:   clear forces zero, used at start and stop
`timescale 1ns/1ps
`default_nettype none
module period_counter (
	input  wire logic                              clk_sys,
	input  wire logic                              srst,
	input  wire logic                              run,
	input  wire logic                              clear,
	input  wire logic [toggle_timer_pkg::CNT_W-1:0] period,
	output logic      [toggle_timer_pkg::CNT_W-1:0] count
);

	// ------------------------------------------------------------
	// counting
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst || clear) begin
			count <= toggle_timer_pkg::CNT_RST;
		end else if (run) begin
			if (count >= period) begin
				count <= toggle_timer_pkg::CNT_RST;
			end else begin
				count <= count + 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// *** hw/toggle_channel.sv ***
// Purpose: one output channel that toggles on compare match
// Assumes: compare value is live, no shadow copy
// Notes:   wrap of the counter leaves the level alone
`timescale 1ns/1ps
`default_nettype none
module toggle_channel (
	input  wire logic                              clk_sys,
	input  wire logic                              srst,
	input  wire logic                              run,
	input  wire logic                              force_low,
	input  wire logic [toggle_timer_pkg::CNT_W-1:0] count,
	input  wire logic [toggle_timer_pkg::CNT_W-1:0] compare,
	output logic                                   level
);

	// ------------------------------------------------------------
	// output level
	// ------------------------------------------------------------
	// no negation override exists, so level changes only on a match, the force_low clear or srst
	always_ff @(posedge clk_sys) begin
		if (srst || force_low) begin
			level <= 1'b0;
		end else if (run && count == compare) begin
			level <= ~level;
		end
		// period wrap has no branch here on purpose
	end

endmodule
`default_nettype wire

// *** hw/dual_toggle_compare_timer.sv ***
// Purpose: two-channel toggle-on-match timer with register port
// Assumes: bus master strobes are single cycle and never overlap
// Notes:   compare writes take effect at once, without waiting for the next counter cycle
`timescale 1ns/1ps
`default_nettype none

// Contract
// - compare the counter against a separate value per channel, 5999 and 9999
// - on a match, invert that channel's output level
// - drive both outputs low when counting starts and when it stops
// - counter wrap leaves both output levels unchanged
// - compare values are used directly, no buffered transfer
// - no negation override ever forces an output level
// - both pins are waveform outputs shaped only by their matches, the start and stop clears and srst
module dual_toggle_compare_timer (
	input  wire logic                               clk_sys,
	input  wire logic                               srst,
	input  wire logic [toggle_timer_pkg::ADDR_W-1:0] bus_addr,
	input  wire logic [31:0]                        bus_wdata,
	input  wire logic                               bus_wr,
	input  wire logic                               bus_rd,
	output logic      [31:0]                        bus_rdata,
	output logic                                    timer_output_a,
	output logic                                    timer_output_b
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	localparam int W = toggle_timer_pkg::CNT_W;

	toggle_timer_pkg::bus_req_s   req;
	toggle_timer_pkg::run_state_e state;
	toggle_timer_pkg::run_state_e next_state;
	logic [W-1:0] period;
	logic [W-1:0] compare_value_a;
	logic [W-1:0] compare_value_b;
	logic [W-1:0] count;
	logic         run_req;
	logic         running;
	logic         edge_clear;
	logic         level_a;
	logic         level_b;
	logic [31:0]  next_rdata;

	assign req.addr  = bus_addr;
	assign req.wdata = bus_wdata;
	assign req.wr    = bus_wr;
	assign req.rd    = bus_rd;

	// ------------------------------------------------------------
	// writable registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			run_req <= 1'b0;
		end else if (req.wr && req.addr == toggle_timer_pkg::ADDR_CTRL) begin
			run_req <= req.wdata[toggle_timer_pkg::CTRL_RUN_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			period <= toggle_timer_pkg::PERIOD_RST;
		end else if (req.wr && req.addr == toggle_timer_pkg::ADDR_PERIOD) begin
			period <= req.wdata[W-1:0];
		end
	end

	// direct write, channel sees the new value at once
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			compare_value_a <= toggle_timer_pkg::CMP_A_RST;
		end else if (req.wr && req.addr == toggle_timer_pkg::ADDR_CMP_A) begin
			compare_value_a <= req.wdata[W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			compare_value_b <= toggle_timer_pkg::CMP_B_RST;
		end else if (req.wr && req.addr == toggle_timer_pkg::ADDR_CMP_B) begin
			compare_value_b <= req.wdata[W-1:0];
		end
	end

	// ------------------------------------------------------------
	// run state
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			toggle_timer_pkg::ST_IDLE: begin
				if (run_req) begin
					next_state = toggle_timer_pkg::ST_RUN;
				end
			end
			toggle_timer_pkg::ST_RUN: begin
				if (!run_req) begin
					next_state = toggle_timer_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = toggle_timer_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state <= toggle_timer_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign running    = (state == toggle_timer_pkg::ST_RUN);
	// start and stop both clear count and levels
	assign edge_clear = (state != next_state);

	// ------------------------------------------------------------
	// counter and channels
	// ------------------------------------------------------------
	period_counter u_counter (
		.clk_sys (clk_sys),
		.srst    (srst),
		.run     (running),
		.clear   (edge_clear),
		.period  (period),
		.count   (count)
	);

	toggle_channel u_chan_a (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.run       (running),
		.force_low (edge_clear),
		.count     (count),
		.compare   (compare_value_a),
		.level     (level_a)
	);

	toggle_channel u_chan_b (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.run       (running),
		.force_low (edge_clear),
		.count     (count),
		.compare   (compare_value_b),
		.level     (level_b)
	);

	// pins are plain registered copies, one cycle after the level
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			timer_output_a <= 1'b0;
			timer_output_b <= 1'b0;
		end else begin
			timer_output_a <= level_a;
			timer_output_b <= level_b;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (req.addr)
			toggle_timer_pkg::ADDR_CTRL:
				next_rdata[toggle_timer_pkg::CTRL_RUN_BIT] = run_req;
			toggle_timer_pkg::ADDR_PERIOD: next_rdata[W-1:0] = period;
			toggle_timer_pkg::ADDR_CMP_A:  next_rdata[W-1:0] = compare_value_a;
			toggle_timer_pkg::ADDR_CMP_B:  next_rdata[W-1:0] = compare_value_b;
			toggle_timer_pkg::ADDR_COUNT:  next_rdata[W-1:0] = count;
			toggle_timer_pkg::ADDR_STATUS: begin
				next_rdata[toggle_timer_pkg::STAT_RUN_BIT]   = running;
				next_rdata[toggle_timer_pkg::STAT_OUT_A_BIT] = level_a;
				next_rdata[toggle_timer_pkg::STAT_OUT_B_BIT] = level_b;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// unmapped addresses and idle cycles read zero
	always_ff @(posedge clk_sys) begin
		if (srst || !req.rd) begin
			bus_rdata <= 32'h0000_0000;
		end else begin
			bus_rdata <= next_rdata;
		end
	end

endmodule
`default_nettype wire

// *** dv/converter_model.sv ***
// Purpose: far-side model, timestamps changes of the two pins
// Assumes: pins sampled on the timer clock
// Notes:   judges nothing, the bench reads the stamps
`timescale 1ns/1ps
`default_nettype none
module converter_model (
	input  wire logic clk_sys,
	input  wire logic timer_output_a,
	input  wire logic timer_output_b,
	output var int    stamp_a,
	output var int    stamp_b,
	output var int    gap_a
);
	int   now;
	logic pa;
	logic pb;
	initial begin
		now = 0;
		pa = 1'b0;
		pb = 1'b0;
		stamp_a = 0;
		stamp_b = 0;
		gap_a = 0;
	end
	always @(posedge clk_sys) begin
		now <= now + 1;
		pa <= timer_output_a;
		pb <= timer_output_b;
		if (timer_output_a !== pa) begin
			gap_a <= now - stamp_a;
			stamp_a <= now;
		end
		if (timer_output_b !== pb)
			stamp_b <= now;
	end
endmodule
`default_nettype wire

// *** dv/toggle_timer_sva.sv ***
// Purpose: port-level checks for the dual toggle timer
// Assumes: period left at its reset value
// Notes:   compare values not shadowed, gaps bounded above only
`timescale 1ns/1ps
`default_nettype none
module toggle_timer_sva (
	input wire logic        clk_sys,
	input wire logic        srst,
	input wire logic [7:0]  bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [31:0] bus_rdata,
	input wire logic        timer_output_a,
	input wire logic        timer_output_b
);
	logic      run_sh;
	int        ga;
	wire logic ctl_wr = bus_wr && bus_addr == 8'h00;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	always_ff @(posedge clk_sys) begin
		if (srst)
			run_sh <= 1'b0;
		else if (ctl_wr)
			run_sh <= bus_wdata[0];
	end
	always_ff @(posedge clk_sys) begin
		if (srst || !run_sh || $changed(timer_output_a))
			ga <= 0;
		else
			ga <= ga + 1;
	end
	// only a real start or stop clears, rewriting the same run bit does not
	a_ctrl_low: assert property (ctl_wr && bus_wdata[0] != run_sh |->
		##3 !timer_output_a && !timer_output_b)
		else $error("pin not low after start or stop");
	a_idle_low: assert property ((!run_sh) [*4] |->
		!timer_output_a && !timer_output_b)
		else $error("pin high while stopped");
	// a match in the stop write cycle may still reach the pin
	a_fall_idle: assert property (!run_sh && !$past(run_sh, 2) &&
		$changed(timer_output_a) |-> !timer_output_a)
		else $error("pin rose while stopped");
	a_rise_run: assert property ($rose(timer_output_b) |->
		run_sh || $past(run_sh, 2))
		else $error("pin b rose while stopped");
	a_single_a: assert property (run_sh && $changed(timer_output_a) |=>
		$stable(timer_output_a))
		else $error("pin a changed twice in a row");
	a_single_b: assert property (run_sh && $changed(timer_output_b) |=>
		$stable(timer_output_b))
		else $error("pin b changed twice in a row");
	a_gap_a: assert property (run_sh |->
		ga <= int'(toggle_timer_pkg::PERIOD_RST))
		else $error("pin a missed a timer cycle");
	a_stat_pins: assert property ($past(bus_rd) &&
		$past(bus_addr) == 8'h14 |-> bus_rdata[2:1] ==
		{timer_output_b, timer_output_a})
		else $error("status levels differ from pins");
endmodule
bind dual_toggle_compare_timer toggle_timer_sva i_toggle_timer_sva (
	.clk_sys(clk_sys), .srst(srst), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .timer_output_a(timer_output_a),
	.timer_output_b(timer_output_b));
`default_nettype wire

// *** dv/dual_toggle_compare_timer_bench.sv ***
// Purpose: self-checking bench for the dual toggle timer
// Assumes: reset period and compare values
// Notes:   one timer cycle is 12000 clocks
`timescale 1ns/1ps
`default_nettype none
module dual_toggle_compare_timer_bench;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0000_0000;
	logic        bus_wr = 1'b0;
	logic        bus_rd = 1'b0;
	logic [31:0] bus_rdata;
	logic        timer_output_a;
	logic        timer_output_b;
	int          fail_count = 0;
	int          n_compared = 0;
	int          stamp_a;
	int          stamp_b;
	int          gap_a;
	dual_toggle_compare_timer i_dual_toggle_compare_timer (
		.clk_sys(clk_sys), .srst(srst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .timer_output_a(timer_output_a),
		.timer_output_b(timer_output_b));
	converter_model i_converter_model (
		.clk_sys(clk_sys), .timer_output_a(timer_output_a),
		.timer_output_b(timer_output_b), .stamp_a(stamp_a),
		.stamp_b(stamp_b), .gap_a(gap_a));
	initial forever #12.5 clk_sys = ~clk_sys;
	task automatic end_of_test();
		$display("compared %0d, bad %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	// idle cycle after each read keeps strobes from double assignment
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		#1;
		chk(bus_rdata, e);
		@(posedge clk_sys);
	endtask
	task automatic wait_pin(input bit on_b);
		int s;
		int k;
		s = on_b ? stamp_b : stamp_a;
		for (k = 0; k < 20000 && s == (on_b ? stamp_b : stamp_a); k++)
			@(posedge clk_sys);
		if (s == (on_b ? stamp_b : stamp_a)) begin
			fail_count++;
			$display("BAD %0t pin never changed", $time);
			end_of_test();
		end
	endtask
	// ------
	// scenarios
	// ------
	task automatic t_reset();
		rd_chk(8'h04, 32'h0000_2EDF);
		rd_chk(8'h08, 32'h0000_176F);
		rd_chk(8'h0C, 32'h0000_270F);
		rd_chk(8'h14, 32'h0000_0000);
	endtask
	task automatic t_run();
		wr(8'h00, 32'h0000_0001);
		repeat (2) @(posedge clk_sys);
		chk({30'h0, timer_output_b, timer_output_a}, 32'h0);
		wait_pin(1'b0);
		wait_pin(1'b1);
		chk(stamp_b - stamp_a, 32'h0000_270F - 32'h0000_176F);
		rd_chk(8'h14, 32'h0000_0007);
		wait_pin(1'b0);
		chk(gap_a, 32'h0000_2EDF + 32'h0000_0001);
	endtask
	task automatic t_live();
		wr(8'h08, 32'h0000_1F3F);
		wait_pin(1'b0);
		chk(gap_a, 32'h0000_1F3F - 32'h0000_176F);
	endtask
	task automatic t_stop();
		int s;
		wr(8'h00, 32'h0000_0000);
		repeat (3) @(posedge clk_sys);
		chk({30'h0, timer_output_b, timer_output_a}, 32'h0);
		s = stamp_a;
		wr(8'h20, 32'h0000_0001);
		wr(8'h10, 32'h0000_0005);
		repeat (100) @(posedge clk_sys);
		chk(stamp_a, s);
		rd_chk(8'h10, 32'h0000_0000);
		rd_chk(8'h20, 32'h0000_0000);
		wr(8'h08, 32'h0000_176F);
	endtask
	// reset while running, pin b is high at that point
	task automatic t_mid_reset();
		srst <= 1'b1;
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		t_reset();
		chk({30'h0, timer_output_b, timer_output_a}, 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		t_reset();
		t_run();
		t_live();
		t_stop();
		t_run();
		t_mid_reset();
		end_of_test();
	end
endmodule
`default_nettype wire
